// *** core/dac_loader_pkg.sv ***
package dac_loader_pkg;
	// -----------------------------------------------------------------
	// register map of the controller (apb, one word each)
	// -----------------------------------------------------------------
	localparam logic [7:0] ctrl_offset   = 8'h00;
	localparam logic [7:0] code_offset   = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;
	localparam logic [7:0] ramp_offset   = 8'h0C;
	localparam logic [7:0] readback_offset = 8'h10;
	localparam logic [7:0] gain_offset   = 8'h14;

	// ctrl field positions
	localparam int ctrl_go_bit     = 0;
	localparam int ctrl_serial_bit = 1;
	localparam int ctrl_short_bit  = 2;
	localparam int ctrl_ramp_bit   = 3;
	localparam int ctrl_zero_bit   = 4;
	localparam int ctrl_read_bit   = 5;
	localparam int ctrl_exp_bit    = 6;

	// reset values
	localparam logic [9:0]  code_reset = 10'h000;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;

	// code geometry
	localparam int code_width  = 10;
	localparam int low_width   = 8;
	localparam int high_width  = 2;
	localparam int short_width = 8;

	// strobe timing: each strobe phase lasts this long
	localparam int clk_period_ns  = 10;
	localparam int strobe_time_ns = 100;
	localparam int strobe_cycles  = (strobe_time_ns + clk_period_ns - 1) / clk_period_ns;

	// ramp: total change spread over at least this time
	localparam int ramp_time_ms     = 50;
	localparam int ramp_total_cycles = ramp_time_ms * 100_000;
	localparam int ramp_step_cycles  = ramp_total_cycles / 1024;

	typedef enum logic [3:0] {
		st_idle,
		st_wait_zero,
		st_setup,
		st_low_hi,
		st_low_lo,
		st_high_hi,
		st_high_lo,
		st_ser_hi,
		st_ser_lo,
		st_latch,
		st_done
	} load_state_t;
endpackage : dac_loader_pkg

// *** core/gain_map.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// exponential map of a step index to a dac code
// -----------------------------------------------------------------
module gain_map (
	input  wire logic       pclk,     // clock
	input  wire logic       presetn,  // async reset, low
	input  wire logic       ce,       // clock enable
	input  wire logic [5:0] index,    // step index, 0 = loudest
	output logic      [9:0] code      // mapped code, registered
);
	logic [9:0] table_mem [0:63];

	// about 1 db per step, two significant digits are enough
	initial begin
		for (int i = 0; i < 64; i++) begin
			table_mem[i] = 10'(int'(1023.0 * (10.0 ** (-real'(i) / 20.0))));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code <= 10'h000;
		end else if (ce) begin
			code <= table_mem[index];
		end
	end
endmodule : gain_map

// *** core/dac_loader_host.sv ***
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
// Functional notes
// - a full word goes as two byte transfers or one wide one; the host presents both segments.
// - gain changes under signal are ramped by a clock and preset counter over 50 ms or more.
// - as an alternative, code changes wait until the signal is near zero.
// - equal-db steps map a counter through a lookup table to an exponential code.
// - the host drives unused code lines low; the pins of the mode not in use still follow the word.
// - serial/parallel select low means parallel, high means serial.
// - rising segment strobes capture bus lines in parallel and shift one place in serial.
// - update control low holds the latches; high passes the input register through.
// - short-cycle low bypasses the two lsbs for 8 bits; high takes a full 10-bit word.
module dac_loader_host #(
	parameter int ramp_step_cycles = dac_loader_pkg::ramp_step_cycles  // cycles per ramp step
) (
	input  wire logic        pclk,                   // clock, 100 mhz
	input  wire logic        presetn,                // async reset, low
	input  wire logic        ce,                     // clock enable
	input  wire logic        psel,                   // apb select
	input  wire logic        penable,                // apb enable
	input  wire logic        pwrite,                 // apb direction
	input  wire logic [7:0]  paddr,                  // apb byte address
	input  wire logic [31:0] pwdata,                 // apb write data
	output logic      [31:0] prdata,                 // apb read data
	output logic             pready,                 // apb ready
	output logic             pslverr,                // apb error
	input  wire logic        signal_near_zero,       // audio zero-cross indication
	output logic      [9:0]  code_inputs,            // dac parallel code pins
	output logic             serial_parallel_select, // dac mode pin
	output logic             low_segment_strobe,     // dac low strobe
	output logic             high_segment_strobe,    // dac high strobe
	output logic             latch_update_control,   // dac load/display
	output logic             short_cycle_select,     // dac short cycle
	output logic             serial_shift_in,        // dac serial data
	input  wire logic        serial_recovery_out     // dac serial readback pin
);
	// -----------------------------------------------------------------
	// registers and bus slave
	// -----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [9:0]  target;
	logic [5:0]  gain_index;
	logic [9:0]  ramp_code;
	logic [9:0]  readback;
	logic        busy;
	logic        go_req;
	logic [9:0]  mapped;
	dac_loader_pkg::load_state_t state;
	logic [9:0]  word;
	logic [3:0]  bit_cnt;
	logic [7:0]  phase_cnt;
	logic [31:0] step_cnt;
	logic [2:0]  rb_sync;
	logic        rb_bit;
	logic        wr_ok;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr == dac_loader_pkg::ctrl_offset ||
		paddr == dac_loader_pkg::code_offset || paddr == dac_loader_pkg::status_offset ||
		paddr == dac_loader_pkg::ramp_offset || paddr == dac_loader_pkg::readback_offset ||
		paddr == dac_loader_pkg::gain_offset);
	assign wr_ok = psel && penable && pwrite && ce;

	// read mux: zero for unmapped addresses
	always_comb begin
		unique case (paddr)
			dac_loader_pkg::ctrl_offset:     prdata = {ctrl[31:1], 1'b0};
			dac_loader_pkg::code_offset:     prdata = {22'h00_0000, target};
			dac_loader_pkg::status_offset:   prdata = {31'h0000_0000, busy};
			dac_loader_pkg::ramp_offset:     prdata = {22'h00_0000, ramp_code};
			dac_loader_pkg::readback_offset: prdata = {22'h00_0000, readback};
			dac_loader_pkg::gain_offset:     prdata = {26'h000_0000, gain_index};
			default:                         prdata = 32'h0000_0000;
		endcase
	end

	// control register; go is a level request that stays set until written low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl       <= dac_loader_pkg::ctrl_reset;
			target     <= dac_loader_pkg::code_reset;
			gain_index <= 6'h00;
		end else if (ce) begin
			if (wr_ok && paddr == dac_loader_pkg::ctrl_offset) begin
				ctrl <= pwdata;
			end
			if (wr_ok && paddr == dac_loader_pkg::code_offset) begin
				target <= pwdata[9:0];
			end
			if (wr_ok && paddr == dac_loader_pkg::gain_offset) begin
				gain_index <= pwdata[5:0];
			end
		end
	end
	assign go_req = ctrl[dac_loader_pkg::ctrl_go_bit];

	gain_map u_map (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.index   (gain_index),
		.code    (mapped)
	);

	// -----------------------------------------------------------------
	// readback pin synchroniser: three flops, change when 2 and 3 agree
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_sync <= 3'b000;
			rb_bit  <= 1'b0;
		end else if (ce) begin
			rb_sync <= {rb_sync[1:0], serial_recovery_out};
			if (rb_sync[1] == rb_sync[2]) begin
				rb_bit <= rb_sync[2];
			end
		end
	end

	// -----------------------------------------------------------------
	// load sequencer
	// -----------------------------------------------------------------
	// ramp steps one lsb at a time toward the goal; the dac starts at zero
	logic [9:0] goal;
	assign goal = ctrl[dac_loader_pkg::ctrl_exp_bit] ? mapped : target;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= dac_loader_pkg::st_idle;
			word       <= 10'h000;
			bit_cnt    <= 4'h0;
			phase_cnt  <= 8'h00;
			step_cnt   <= 32'h0000_0000;
			ramp_code  <= dac_loader_pkg::code_reset;
			readback   <= 10'h000;
			busy       <= 1'b0;
		end else if (ce) begin
			unique case (state)
				dac_loader_pkg::st_idle: begin
					busy <= 1'b0;
					if (ctrl[dac_loader_pkg::ctrl_ramp_bit] && ramp_code != goal) begin
						if (step_cnt >= 32'(ramp_step_cycles - 1)) begin
							step_cnt <= 32'h0000_0000;
							word     <= (ramp_code < goal) ? ramp_code + 10'h001 : ramp_code - 10'h001;
							busy     <= 1'b1;
							state    <= dac_loader_pkg::st_wait_zero;
						end else begin
							step_cnt <= step_cnt + 32'h0000_0001;
						end
					end else if (go_req && !ctrl[dac_loader_pkg::ctrl_ramp_bit]) begin
						word  <= goal;
						busy  <= 1'b1;
						state <= dac_loader_pkg::st_wait_zero;
					end
				end
				// hold off the change until the audio is near zero
				dac_loader_pkg::st_wait_zero: begin
					if (!ctrl[dac_loader_pkg::ctrl_zero_bit] || signal_near_zero) begin
						phase_cnt <= 8'h00;
						bit_cnt   <= 4'h0;
						state     <= dac_loader_pkg::st_setup;
					end
				end
				// mode pins settle before the first strobe edge
				dac_loader_pkg::st_setup: begin
					phase_cnt <= phase_cnt + 8'h01;
					if (phase_cnt == 8'(dac_loader_pkg::strobe_cycles - 1)) begin
						phase_cnt <= 8'h00;
						state <= ctrl[dac_loader_pkg::ctrl_serial_bit] ? dac_loader_pkg::st_ser_lo
							: dac_loader_pkg::st_low_hi;
					end
				end
				// low segment, then high segment, both before the latch
				dac_loader_pkg::st_low_hi, dac_loader_pkg::st_low_lo,
				dac_loader_pkg::st_high_hi, dac_loader_pkg::st_high_lo: begin
					phase_cnt <= phase_cnt + 8'h01;
					if (phase_cnt == 8'(dac_loader_pkg::strobe_cycles - 1)) begin
						phase_cnt <= 8'h00;
						unique case (state)
							dac_loader_pkg::st_low_hi:  state <= dac_loader_pkg::st_low_lo;
							dac_loader_pkg::st_low_lo:  state <= dac_loader_pkg::st_high_hi;
							dac_loader_pkg::st_high_hi: state <= dac_loader_pkg::st_high_lo;
							default:                    state <= dac_loader_pkg::st_latch;
						endcase
					end
				end
				// serial: msb first, data set while strobes are low
				dac_loader_pkg::st_ser_lo: begin
					phase_cnt <= phase_cnt + 8'h01;
					if (phase_cnt == 8'(dac_loader_pkg::strobe_cycles - 1)) begin
						phase_cnt <= 8'h00;
						if (bit_cnt == (ctrl[dac_loader_pkg::ctrl_short_bit] ? 4'd8 : 4'd10)) begin
							state <= dac_loader_pkg::st_latch;
						end else begin
							// sample before each shift, so in 10-bit mode the stored word comes back whole, msb first
							readback <= {readback[8:0], rb_bit};
							state    <= dac_loader_pkg::st_ser_hi;
						end
					end
				end
				dac_loader_pkg::st_ser_hi: begin
					phase_cnt <= phase_cnt + 8'h01;
					if (phase_cnt == 8'(dac_loader_pkg::strobe_cycles - 1)) begin
						phase_cnt <= 8'h00;
						bit_cnt   <= bit_cnt + 4'h1;
						state     <= dac_loader_pkg::st_ser_lo;
					end
				end
				// update pulse passes the input register into the latches
				dac_loader_pkg::st_latch: begin
					phase_cnt <= phase_cnt + 8'h01;
					if (phase_cnt == 8'(dac_loader_pkg::strobe_cycles - 1)) begin
						phase_cnt <= 8'h00;
						state     <= dac_loader_pkg::st_done;
					end
				end
				dac_loader_pkg::st_done: begin
					ramp_code <= word; // the dac now shows this code, ramp or not, save the two lsbs after a short-cycle load
					state     <= dac_loader_pkg::st_idle;
				end
				default: state <= dac_loader_pkg::st_idle;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// pin drive, all from flops or state; every pin driven
	// -----------------------------------------------------------------
	logic [3:0] ser_index;
	assign ser_index = 4'd9 - bit_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_inputs            <= 10'h000;
			serial_parallel_select <= 1'b0;
			low_segment_strobe     <= 1'b0;
			high_segment_strobe    <= 1'b0;
			latch_update_control   <= 1'b0;
			short_cycle_select     <= 1'b1;
			serial_shift_in        <= 1'b0;
		end else if (ce) begin
			serial_parallel_select <= ctrl[dac_loader_pkg::ctrl_serial_bit];
			short_cycle_select     <= !ctrl[dac_loader_pkg::ctrl_short_bit];
			// byte bus: low byte on bits 7:0, high pair on bits 1:0
			// the pair goes out a cycle after the low strobe falls, long before the high strobe
			// rises, so no segment sees its lines move at its own edge
			code_inputs <= (state == dac_loader_pkg::st_high_hi || state == dac_loader_pkg::st_high_lo ||
				(state == dac_loader_pkg::st_low_lo && phase_cnt != 8'h00))
				? {8'h00, word[9:8]} : {2'b00, word[7:0]};
			low_segment_strobe  <= (state == dac_loader_pkg::st_low_hi) || (state == dac_loader_pkg::st_ser_hi);
			high_segment_strobe <= (state == dac_loader_pkg::st_high_hi) || (state == dac_loader_pkg::st_ser_hi);
			latch_update_control <= (state == dac_loader_pkg::st_latch); // display otherwise
			serial_shift_in <= (bit_cnt < 4'd10) ? word[ser_index] : 1'b0;
		end
	end
endmodule : dac_loader_host

// *** bench/dac_loader_host_sva.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// port checks on the dac loader host
// -----------------------------------------------------------------
module dac_loader_host_sva (
	input wire logic        pclk, presetn, ce, psel, penable, pwrite, // clock, reset, apb controls
	input wire logic [7:0]  paddr,                                    // apb address
	input wire logic [31:0] pwdata, prdata,                           // apb data
	input wire logic        pready, pslverr, signal_near_zero,        // apb answer, zero flag
	input wire logic [9:0]  code_inputs,                              // dac code pins
	input wire logic        serial_parallel_select, low_segment_strobe, high_segment_strobe, // dac controls
	input wire logic        latch_update_control, short_cycle_select,                         // dac controls
	input wire logic        serial_shift_in, serial_recovery_out                              // serial pins
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// decoded map; any other offset must be refused
	logic mapped;
	assign mapped = paddr inside {dac_loader_pkg::ctrl_offset, dac_loader_pkg::code_offset,
		dac_loader_pkg::status_offset, dac_loader_pkg::ramp_offset, dac_loader_pkg::readback_offset,
		dac_loader_pkg::gain_offset};
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
	property p_err_phase; pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("error outside access");
	property p_err_map; psel && penable && !mapped |-> pslverr; endproperty
	a_err_map: assert property (p_err_map) else $error("unmapped access accepted");
	property p_par_apart; !serial_parallel_select |-> !(low_segment_strobe && high_segment_strobe); endproperty
	a_par_apart: assert property (p_par_apart) else $error("segment strobes overlap");
	property p_ser_pair; serial_parallel_select |-> low_segment_strobe == high_segment_strobe; endproperty
	a_ser_pair: assert property (p_ser_pair) else $error("serial strobes apart");
	property p_strobe_len; $rose(low_segment_strobe) |->
		low_segment_strobe[*8] ##1 low_segment_strobe[*2] ##1 !low_segment_strobe; endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
	property p_latch_quiet; latch_update_control |-> !low_segment_strobe && !high_segment_strobe; endproperty
	a_latch_quiet: assert property (p_latch_quiet) else $error("update during strobe");
	property p_latch_len; $rose(latch_update_control) |->
		latch_update_control[*8] ##1 latch_update_control[*2] ##1 !latch_update_control; endproperty
	a_latch_len: assert property (p_latch_len) else $error("update width wrong");
	property p_mode_steady; low_segment_strobe || high_segment_strobe |->
		$stable(serial_parallel_select) && $stable(short_cycle_select); endproperty
	a_mode_steady: assert property (p_mode_steady) else $error("mode moved under strobe");
	property p_low_setup; $rose(low_segment_strobe) && !serial_parallel_select |-> $stable(code_inputs); endproperty
	a_low_setup: assert property (p_low_setup) else $error("code changed at strobe");
	property p_high_setup; $rose(high_segment_strobe) && !serial_parallel_select |-> $stable(code_inputs); endproperty
	a_high_setup: assert property (p_high_setup) else $error("code changed at high strobe");
endmodule : dac_loader_host_sva

bind dac_loader_host dac_loader_host_sva dac_loader_host_sva_i (.*);

// *** bench/dac_device_model.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// behavioural double-buffered dac input structure
// -----------------------------------------------------------------
module dac_device_model (
	input  wire logic       presetn,                // bench clear, the part has none
	input  wire logic [9:0] code_inputs,            // parallel code pins
	input  wire logic       serial_parallel_select, // low parallel, high serial
	input  wire logic       low_segment_strobe,     // low segment strobe
	input  wire logic       high_segment_strobe,    // high segment strobe
	input  wire logic       latch_update_control,   // load or display
	input  wire logic       short_cycle_select,     // low means 8-bit serial
	input  wire logic       serial_shift_in,        // serial data
	output logic            serial_recovery_out,    // input register msb
	output logic      [9:0] held                    // holding latches
);
	logic [9:0] in_reg;   // edge-triggered input register
	logic [7:0] low_reg;  // low segment
	logic [1:0] high_reg; // high segment
	assign in_reg = {high_reg, low_reg};
	// low segment: bus byte in parallel, shift stage in serial
	always @(posedge low_segment_strobe or negedge presetn) begin
		if (!presetn) low_reg <= 8'h00;
		else if (!serial_parallel_select) low_reg <= code_inputs[7:0];
		else if (!short_cycle_select) low_reg[7:2] <= {low_reg[6:2], serial_shift_in};
		else low_reg <= {low_reg[6:0], serial_shift_in};
	end
	// high segment takes the two lowest bus lines; in serial it takes the old top of the low segment,
	// which holds because both strobes rise together and both sides use non-blocking updates
	always @(posedge high_segment_strobe or negedge presetn) begin
		if (!presetn) high_reg <= 2'b00;
		else if (!serial_parallel_select) high_reg <= code_inputs[1:0];
		else high_reg <= {high_reg[0], low_reg[7]};
	end
	// level latches; display mode keeps the converter away from the register
	always @* begin
		if (!presetn) held = 10'h000;
		else if (latch_update_control) held = in_reg;
	end
	assign serial_recovery_out = in_reg[9];
endmodule : dac_device_model

// *** bench/tb_dac_loader_host.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
	$display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
// -----------------------------------------------------------------
// bench: apb tasks and load sequences against the dac model
// -----------------------------------------------------------------
module tb_dac_loader_host;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, signal_near_zero, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [9:0]  code_inputs, held, prev;
	logic        serial_parallel_select, low_segment_strobe, high_segment_strobe;
	logic        latch_update_control, short_cycle_select, serial_shift_in, serial_recovery_out;
	logic [9:0]  pan [4] = '{10'h3FF, 10'h000, 10'h200, 10'h2A5};
	int          bad_count, comparisons;
	dac_loader_host #(.ramp_step_cycles(4)) dac_loader_host_i (.*);
	dac_device_model dac_device_model_i (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// one transfer; the request stands until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) bad_count++;
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// poll status until busy reaches the wanted level
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, dac_loader_pkg::status_offset, 32'h0000_0000);
			n++;
		end while (rdata[0] !== v && n < 2000);
		`CHK(rdata[0], v)
	endtask : wait_busy
	// poll one register until it shows the wanted word; the caller compares afterwards
	task automatic poll(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0000_0000);
			n++;
		end while (rdata !== v && n < 2000);
	endtask : poll
	// go is a level, so it is dropped once busy shows to avoid a repeat load
	task automatic load(input logic [31:0] ctrl, input logic [9:0] code, input logic [9:0] exp);
		prev = held;
		apb(1'b1, dac_loader_pkg::code_offset, 32'(code));
		apb(1'b1, dac_loader_pkg::ctrl_offset, ctrl);
		wait_busy(1'b1);
		if (ctrl[4]) begin
			repeat (80) @(posedge pclk);
			`CHK(held, prev)
			signal_near_zero <= 1'b1;
		end
		apb(1'b1, dac_loader_pkg::ctrl_offset, ctrl & 32'hFFFF_FFFE);
		wait_busy(1'b0);
		`CHK(held, exp)
	endtask : load
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	// watchdog: the sequence needs about twelve hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		end_sim();
	end
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		signal_near_zero = 1'b1;
		bad_count = 0;
		comparisons = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(held, 10'h000)
		apb(1'b0, dac_loader_pkg::ctrl_offset, 32'h0000_0000);
		`CHK(rdata, dac_loader_pkg::ctrl_reset)
		apb(1'b0, 8'h3C, 32'h0000_0000);
		`CHK(err, 1'b1)
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		apb(1'b1, dac_loader_pkg::code_offset, 32'h0000_03AA);
		ce <= 1'b1;
		apb(1'b0, dac_loader_pkg::code_offset, 32'h0000_0000);
		`CHK(rdata, 32'h0000_0000)
		$display("test reset done");
		foreach (pan[i]) load(32'h0000_0001, pan[i], pan[i]);
		$display("test parallel done");
		prev = held;
		apb(1'b1, dac_loader_pkg::code_offset, 32'h0000_0111);
		repeat (20) @(posedge pclk);
		`CHK(held, prev)
		$display("test display done");
		load(32'h0000_0003, 10'h155, 10'h155);
		// the word shifted out is the one left by the last parallel load
		apb(1'b0, dac_loader_pkg::readback_offset, 32'h0000_0000);
		`CHK(rdata, 32'h0000_02A5)
		$display("test serial done");
		// top eight bits land over the two lsbs left by the last word
		load(32'h0000_0007, 10'h0CF, 10'h0CD);
		$display("test short cycle done");
		signal_near_zero <= 1'b0;
		load(32'h0000_0011, 10'h0F0, 10'h0F0);
		$display("test zero wait done");
		// ramp from the last code, one lsb per step, no go needed
		apb(1'b1, dac_loader_pkg::code_offset, 32'h0000_00F3);
		apb(1'b1, dac_loader_pkg::ctrl_offset, 32'h0000_0008);
		poll(dac_loader_pkg::ramp_offset, 32'h0000_00F1);
		`CHK(rdata, 32'h0000_00F1)
		poll(dac_loader_pkg::ramp_offset, 32'h0000_00F3);
		`CHK(rdata, 32'h0000_00F3)
		`CHK(held, 10'h0F3)
		apb(1'b1, dac_loader_pkg::ctrl_offset, 32'h0000_0000);
		$display("test ramp done");
		// twenty steps of one db each give a tenth of full scale
		apb(1'b1, dac_loader_pkg::gain_offset, 32'h0000_0014);
		load(32'h0000_0041, 10'h000, 10'h066);
		$display("test gain map done");
		end_sim();
	end
endmodule : tb_dac_loader_host
